// ---- common/dwr_pkg.sv ----
// Constants, register map and types of the standby wake-ready block.
// Assumes one 125 MHz clock and 32-bit APB register access.
package dwr_pkg;
	// Clock
	localparam int CLK_PERIOD_PS = 8000;

	// Register byte offsets
	localparam logic [11:0] OFS_FLAG = 12'h000;
	localparam logic [11:0] OFS_WAKE_EN = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h00c;
	localparam logic [11:0] OFS_IRQ_EN = 12'h010;
	localparam logic [11:0] OFS_IRQ_CLR = 12'h014;

	// Configuration flag fields
	localparam int FLAG_W = 16;
	localparam int FLAG_SELF_POWERED = 0;
	localparam int FLAG_REMOTE_WAKEUP_ALLOW = 1;
	localparam int FLAG_EVENT_PIN_SELECT = 12;
	localparam int FLAG_EVENT_OUTPUT_POLARITY = 13;
	localparam int FLAG_EVENT_OUTPUT_TYPE = 14;
	localparam int FLAG_EVENT_INDICATOR_STYLE = 15;
	localparam int FLAG_EVT_LSB = 12;
	localparam logic [3:0] FLAG_EVT_READY = 4'h7;
	localparam logic [15:0] FLAG_RST = 16'h7003;

	// Wake enable fields
	localparam int WEN_W = 3;
	localparam int WEN_FRAME = 0;
	localparam int WEN_PATTERN = 1;
	localparam int WEN_LINK = 2;
	localparam logic [2:0] WEN_RST = 3'h0;

	// Interrupt status fields
	localparam int IRQ_W = 5;
	localparam int IRQ_PACKET = 0;
	localparam int IRQ_EXT = 1;
	localparam int IRQ_FRAME = 2;
	localparam int IRQ_LINK = 3;
	localparam int IRQ_EXIT = 4;
	localparam logic [4:0] IRQ_RST = 5'h00;

	// Timing
	// Covers three sync flops plus the agreement stage
	localparam int STRAP_SETTLE_CYC = 5;
	localparam int EVT_PULSE_NS = 1000;
	localparam int EVT_PULSE_CYC = (EVT_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		DWR_INIT = 2'b00,
		DWR_READY = 2'b01,
		DWR_NORMAL = 2'b10
	} dwr_state_t;
endpackage : dwr_pkg

// ---- rtl/dwr_sync.sv ----
// Three-flop input synchroniser with agreement filter.
// Assumes an asynchronous level from a pin; output is a clean level.
`timescale 1ns/100ps
module dwr_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic din,
	output logic dout
);
	logic s1_r, s2_r, s3_r, lvl_r;
	logic lvl_nxt;

	// Only the second stage reads the first
	always_comb begin
		lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			lvl_r <= RST_VAL;
		end else if (ce) begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign dout = lvl_r;
endmodule : dwr_sync

// ---- rtl/dwr_event_out.sv ----
// Event output pin driver: static or pulsed, polarity and drive type.
// Assumes fire is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps
module dwr_event_out
	import dwr_pkg::*;
#(
	parameter int PULSE_CYC = EVT_PULSE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic fire,
	input wire logic pulse_style,
	input wire logic active_high,
	input wire logic push_pull,
	input wire logic pin_select,
	output logic active,
	output logic pin_out,
	output logic pin_oe_n
);
	logic active_r, active_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic out_r, out_nxt, oe_n_r, oe_n_nxt;

	always_comb begin
		active_nxt = active_r;
		cnt_nxt = cnt_r;
		if (fire) begin
			active_nxt = 1'b1;
			cnt_nxt = 16'(PULSE_CYC);
		end else if (active_r && pulse_style) begin
			// Static style never drops; only reset ends it
			if (cnt_r <= 16'h0001) begin
				active_nxt = 1'b0;
				cnt_nxt = 16'h0000;
			end else begin
				cnt_nxt = cnt_r - 16'h0001;
			end
		end
		out_nxt = active_nxt ? active_high : ~active_high;
		// Open drain only pulls low
		oe_n_nxt = ~(pin_select && (push_pull || !out_nxt));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_r <= 1'b0;
			cnt_r <= 16'h0000;
			out_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else if (ce) begin
			active_r <= active_nxt;
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign active = active_r;
	assign pin_out = out_r;
	assign pin_oe_n = oe_n_r;
endmodule : dwr_event_out

// ---- rtl/dwr_wake_ready.sv ----
// Standby wake-ready control with APB registers and wake interrupt.
// Assumes wake detectors and USB core on pclk; strap and wake pin are async.
//
// Contract
// R1: Pin zero gives event output; strap selects mode
// R2: Mode needs self-powered flag bit zero
// R3: Mode disables transceiver, keeps PHY and detector
// R4: USB data pins float during mode
// R5: Wake packet or external wake asserts event
// R6: Wake packet in mode asserts event
// R7: After event, leave mode and enumerate
// R8: Static style holds event until reset
// R9: Reset re-enters mode if strap high
// R10: Event bits forced to 0111 in mode
// R11: Remote wake needs flag, feature, enable; external wake (ext_fall) skips the enable
// R12: Power controller powers host on event
`timescale 1ns/100ps
module dwr_wake_ready
	import dwr_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int PULSE_CYC = EVT_PULSE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic strap_mode_in,
	input wire logic external_wake_in_low,
	input wire logic wake_packet_ok,
	input wire logic wake_frame_ok,
	input wire logic link_change,
	input wire logic usb_suspend,
	input wire logic host_rwu_feature,
	input wire logic usb_dp_core_out,
	input wire logic usb_dp_core_oe_n,
	input wire logic usb_dm_core_out,
	input wire logic usb_dm_core_oe_n,
	output logic usb_dp_out,
	output logic usb_dp_oe_n,
	output logic usb_dm_out,
	output logic usb_dm_oe_n,
	output logic usb_xcvr_enable,
	output logic phy_enable,
	output logic autoneg_enable,
	output logic wake_detect_enable,
	output logic usb_connect_start,
	output logic remote_wake_req,
	output logic power_event_out,
	output logic power_event_oe_n,
	output logic irq
);
	dwr_state_t st_r, st_nxt;
	logic [2:0] settle_r, settle_nxt;
	logic [FLAG_W-1:0] flag_r, flag_nxt;
	logic [WEN_W-1:0] wen_r, wen_nxt;
	logic [IRQ_W-1:0] ist_r, ist_nxt, ien_r, ien_nxt, ievt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic irq_r, irq_nxt;
	logic dp_out_r, dp_oe_n_r, dm_out_r, dm_oe_n_r;
	logic xcvr_r, phy_r, conn_r, conn_nxt, rwu_r, rwu_nxt;
	logic strap_lvl, ext_lvl, ext_prev_r, ext_fall;
	logic evt_fire, evt_active, ready;
	logic wr_en, rd_phase;
	logic [ADDR_W-1:0] ofs;

	function automatic logic [15:0] strb16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		strb16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : strb16

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] o);
		hit = (a == ADDR_W'(o));
	endfunction : hit

	// Async pins: three flops, agreement filter
	dwr_sync #(.RST_VAL(1'b0)) u_strap_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.din(strap_mode_in),
		.dout(strap_lvl)
	);

	dwr_sync #(.RST_VAL(1'b1)) u_ext_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.din(external_wake_in_low),
		.dout(ext_lvl)
	);

	assign ext_fall = ext_prev_r & ~ext_lvl;
	assign ready = (st_r == DWR_READY);

	// Wake events in mode; static hold lives in the pin driver
	assign evt_fire = ready && (wake_packet_ok || ext_fall); // R5 R6

	dwr_event_out #(.PULSE_CYC(PULSE_CYC)) u_evt (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.fire(evt_fire),
		.pulse_style(flag_r[FLAG_EVENT_INDICATOR_STYLE]), // R8
		.active_high(flag_r[FLAG_EVENT_OUTPUT_POLARITY]), // R10
		.push_pull(flag_r[FLAG_EVENT_OUTPUT_TYPE]),
		.pin_select(flag_r[FLAG_EVENT_PIN_SELECT]), // R1
		.active(evt_active),
		.pin_out(power_event_out),
		.pin_oe_n(power_event_oe_n)
	);

	// Mode sequencing
	always_comb begin
		st_nxt = st_r;
		settle_nxt = settle_r;
		conn_nxt = 1'b0;
		unique case (st_r)
			DWR_INIT: begin
				// Strap seen only after the synchroniser has filled
				if (settle_r == 3'(STRAP_SETTLE_CYC - 1)) begin
					if (strap_lvl && flag_r[FLAG_SELF_POWERED]) begin // R1 R2 R9
						st_nxt = DWR_READY;
					end else begin
						st_nxt = DWR_NORMAL; // R9
						conn_nxt = 1'b1;
					end
				end else begin
					settle_nxt = settle_r + 3'h1;
				end
			end
			DWR_READY: begin
				if (evt_fire) begin
					st_nxt = DWR_NORMAL; // R7
					conn_nxt = 1'b1;
				end
			end
			DWR_NORMAL: begin
				st_nxt = DWR_NORMAL;
			end
			default: begin
				st_nxt = DWR_INIT;
			end
		endcase
	end

	// Remote wake from normal suspend
	always_comb begin
		rwu_nxt = 1'b0;
		if (st_r == DWR_NORMAL && usb_suspend && flag_r[FLAG_REMOTE_WAKEUP_ALLOW] &&
			host_rwu_feature) begin
			rwu_nxt = (wake_frame_ok && wen_r[WEN_FRAME]) ||
				(wake_packet_ok && wen_r[WEN_PATTERN]) ||
				(link_change && wen_r[WEN_LINK]) || ext_fall; // R11
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= DWR_INIT;
			settle_r <= 3'h0;
			conn_r <= 1'b0;
			rwu_r <= 1'b0;
			ext_prev_r <= 1'b1;
		end else if (ce) begin
			st_r <= st_nxt;
			settle_r <= settle_nxt;
			conn_r <= conn_nxt;
			rwu_r <= rwu_nxt;
			ext_prev_r <= ext_lvl;
		end
	end

	// USB pads and power domains, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dp_out_r <= 1'b0;
			dm_out_r <= 1'b0;
			dp_oe_n_r <= 1'b1;
			dm_oe_n_r <= 1'b1;
			xcvr_r <= 1'b0;
			phy_r <= 1'b0;
		end else if (ce) begin
			// Pads float until the normal state is reached
			dp_out_r <= (st_r == DWR_NORMAL) ? usb_dp_core_out : 1'b0;
			dm_out_r <= (st_r == DWR_NORMAL) ? usb_dm_core_out : 1'b0;
			dp_oe_n_r <= (st_r == DWR_NORMAL) ? usb_dp_core_oe_n : 1'b1; // R4
			dm_oe_n_r <= (st_r == DWR_NORMAL) ? usb_dm_core_oe_n : 1'b1; // R4
			xcvr_r <= (st_r == DWR_NORMAL); // R3
			phy_r <= 1'b1; // R3
		end
	end

	// APB slave: access phase takes two cycles
	assign ofs = paddr;
	assign rd_phase = psel && penable && !pready_r;
	assign wr_en = psel && penable && pready_r && pwrite;

	always_comb begin
		pready_nxt = rd_phase;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		if (rd_phase) begin
			prdata_nxt = 32'h0000_0000;
			if (hit(ofs, OFS_FLAG)) begin
				prdata_nxt = {16'h0000, flag_r};
			end else if (hit(ofs, OFS_WAKE_EN)) begin
				prdata_nxt = {29'h0, wen_r};
			end else if (hit(ofs, OFS_STATUS)) begin
				prdata_nxt = {27'h0, xcvr_r, strap_lvl, evt_active, st_r};
			end else if (hit(ofs, OFS_IRQ_STAT)) begin
				prdata_nxt = {27'h0, ist_r};
			end else if (hit(ofs, OFS_IRQ_EN)) begin
				prdata_nxt = {27'h0, ien_r};
			end else if (!hit(ofs, OFS_IRQ_CLR)) begin
				pslverr_nxt = 1'b1;
			end
		end
	end

	// Writable registers and sticky status
	assign ievt = {conn_r && (st_r == DWR_NORMAL), link_change, wake_frame_ok,
		ext_fall, wake_packet_ok};

	always_comb begin
		flag_nxt = flag_r;
		wen_nxt = wen_r;
		ien_nxt = ien_r;
		ist_nxt = ist_r;
		if (wr_en && hit(ofs, OFS_FLAG)) begin
			flag_nxt = strb16(flag_r, pwdata, pstrb);
		end
		if (wr_en && hit(ofs, OFS_WAKE_EN) && pstrb[0]) begin
			wen_nxt = pwdata[WEN_W-1:0];
		end
		if (wr_en && hit(ofs, OFS_IRQ_EN) && pstrb[0]) begin
			ien_nxt = pwdata[IRQ_W-1:0];
		end
		if (wr_en && hit(ofs, OFS_IRQ_CLR) && pstrb[0]) begin
			ist_nxt = ist_r & ~pwdata[IRQ_W-1:0];
		end
		// Set beats a clear in the same cycle
		ist_nxt = ist_nxt | ievt;
		// Event field locked while standing ready
		if (st_nxt == DWR_READY) begin
			flag_nxt[FLAG_EVT_LSB +: 4] = FLAG_EVT_READY; // R10
		end
		irq_nxt = |(ist_nxt & ien_nxt);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= FLAG_RST;
			wen_r <= WEN_RST;
			ien_r <= IRQ_RST;
			ist_r <= IRQ_RST;
			irq_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (ce) begin
			flag_r <= flag_nxt;
			wen_r <= wen_nxt;
			ien_r <= ien_nxt;
			ist_r <= ist_nxt;
			irq_r <= irq_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
	assign usb_dp_out = dp_out_r;
	assign usb_dm_out = dm_out_r;
	assign usb_dp_oe_n = dp_oe_n_r;
	assign usb_dm_oe_n = dm_oe_n_r;
	assign usb_xcvr_enable = xcvr_r;
	assign phy_enable = phy_r;
	assign autoneg_enable = phy_r;
	assign wake_detect_enable = phy_r;
	assign usb_connect_start = conn_r;
	assign remote_wake_req = rwu_r;

	// Checks; a frozen clock enable freezes them too
	default clocking dwr_cb @(posedge pclk iff ce);
	endclocking
	default disable iff (!presetn);

	sequence s_enter_ready;
		(st_r == DWR_INIT) ##1 (st_r == DWR_READY);
	endsequence

	sequence s_leave_init;
		(st_r == DWR_INIT) ##1 (st_r != DWR_INIT);
	endsequence

	sequence s_fire_exit;
		evt_fire ##1 (st_r == DWR_NORMAL);
	endsequence

	property p_pin_select;
		!flag_r[FLAG_EVENT_PIN_SELECT] |=> power_event_oe_n;
	endproperty
	a_pin_select: assert property (p_pin_select) else $error("event pin driven unselected"); // R1

	property p_self_powered;
		s_enter_ready |-> $past(flag_r[FLAG_SELF_POWERED]) && $past(strap_lvl);
	endproperty
	a_self_powered: assert property (p_self_powered) else $error("ready without self power"); // R2

	property p_ready_power;
		(st_r == DWR_READY)[*2] |-> !usb_xcvr_enable && phy_enable && wake_detect_enable;
	endproperty
	a_ready_power: assert property (p_ready_power) else $error("ready power state wrong"); // R3

	property p_ready_hiz;
		(st_r == DWR_READY)[*2] |-> usb_dp_oe_n && usb_dm_oe_n;
	endproperty
	a_ready_hiz: assert property (p_ready_hiz) else $error("usb pads driven in ready"); // R4

	property p_ext_wake;
		(ready && ext_fall) |-> ##2 (evt_active &&
			power_event_out == flag_r[FLAG_EVENT_OUTPUT_POLARITY]);
	endproperty
	a_ext_wake: assert property (p_ext_wake) else $error("external wake missed"); // R5

	property p_packet_wake;
		(ready && wake_packet_ok) |-> ##[1:2] evt_active;
	endproperty
	a_packet_wake: assert property (p_packet_wake) else $error("wake packet missed"); // R6

	property p_exit;
		s_fire_exit |-> usb_connect_start ##1 !usb_connect_start ##1 usb_xcvr_enable;
	endproperty
	a_exit: assert property (p_exit) else $error("mode exit sequence wrong"); // R7

	property p_static_hold;
		(evt_active && !flag_r[FLAG_EVENT_INDICATOR_STYLE]) |=> evt_active;
	endproperty
	a_static_hold: assert property (p_static_hold) else $error("static event dropped"); // R8

	property p_reenter;
		s_leave_init |-> (st_r == DWR_READY) == $past(strap_lvl && flag_r[FLAG_SELF_POWERED]);
	endproperty
	a_reenter: assert property (p_reenter) else $error("mode choice after reset wrong"); // R9

	property p_evt_bits;
		(st_r == DWR_READY) |-> flag_r[FLAG_EVT_LSB +: 4] == FLAG_EVT_READY;
	endproperty
	a_evt_bits: assert property (p_evt_bits) else $error("event bits not 0111 in mode"); // R10

	property p_remote_wake;
		remote_wake_req |-> $past(flag_r[FLAG_REMOTE_WAKEUP_ALLOW] && host_rwu_feature &&
			usb_suspend);
	endproperty
	a_remote_wake: assert property (p_remote_wake) else $error("remote wake not allowed"); // R11
endmodule : dwr_wake_ready

// ---- verif/dwr_pmic_model.sv ----
// Power controller model: turns the host supply on from the event pin.
// Assumes a pull-down on the event pin while the block leaves it undriven.
`timescale 1ns/100ps
module dwr_pmic_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin_out,
	input wire logic pin_oe_n,
	output logic host_power
);
	logic pin_lvl;
	// Undriven pin reads the pull-down
	assign pin_lvl = pin_oe_n ? 1'b0 : pin_out;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_power <= 1'b0;
		end else if (pin_lvl) begin
			host_power <= 1'b1;
		end
	end
endmodule : dwr_pmic_model

// ---- verif/dwr_wake_ready_tb_top.sv ----
// Testbench of the standby wake-ready block: APB tasks and event pulses.
// Assumes one 125 MHz clock; short event pulse parameter.
`timescale 1ns/100ps
module dwr_wake_ready_tb_top;
	import dwr_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, strap = 1, ext = 1, pkt = 0, frm = 0, lnk = 0;
	logic susp = 0, rwuf = 0, dpo = 1, dpoe = 0, dmo = 0, dmoe = 0;
	logic dp_out, dp_oe_n, dm_out, dm_oe_n, xcvr, phy, an, wde, conn, rwr, evt, evt_oe_n;
	logic irq, host_pwr, bad;
	int err_total = 0, num_checks = 0, n_conn = 0, n_rwr = 0, cyc = 0;

	dwr_wake_ready #(.ADDR_W(12), .PULSE_CYC(4)) DUT (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strap_mode_in(strap), .external_wake_in_low(ext), .wake_packet_ok(pkt),
		.wake_frame_ok(frm), .link_change(lnk), .usb_suspend(susp), .host_rwu_feature(rwuf),
		.usb_dp_core_out(dpo), .usb_dp_core_oe_n(dpoe), .usb_dm_core_out(dmo),
		.usb_dm_core_oe_n(dmoe), .usb_dp_out(dp_out), .usb_dp_oe_n(dp_oe_n),
		.usb_dm_out(dm_out), .usb_dm_oe_n(dm_oe_n), .usb_xcvr_enable(xcvr),
		.phy_enable(phy), .autoneg_enable(an), .wake_detect_enable(wde),
		.usb_connect_start(conn), .remote_wake_req(rwr), .power_event_out(evt),
		.power_event_oe_n(evt_oe_n), .irq(irq));
	dwr_pmic_model pmic (.pclk(pclk), .presetn(presetn), .pin_out(evt), .pin_oe_n(evt_oe_n),
		.host_power(host_pwr));

	initial begin
		forever #4 pclk = ~pclk;
	end

	// Pulse outputs last one cycle, so count them at every edge
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (conn === 1'b1) n_conn <= n_conn + 1;
		if (rwr === 1'b1) n_rwr <= n_rwr + 1;
		if (cyc == 5000) begin
			err_total = err_total + 1;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			err_total = err_total + 1;
		end
	endtask : chk

	// Request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	// Strap held well before and after release so the sync settles
	task automatic rst(input logic s);
		@(posedge pclk);
		strap <= s;
		presetn <= 0;
		repeat (6) @(posedge pclk);
		n_conn = 0;
		presetn <= 1;
		repeat (10) @(posedge pclk);
	endtask : rst

	task automatic pls(input logic [2:0] k);
		@(posedge pclk);
		{pkt, frm, lnk} <= k;
		@(posedge pclk);
		{pkt, frm, lnk} <= 3'h0;
		repeat (3) @(posedge pclk);
	endtask : pls

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		rst(1'b1);
		apb(0, OFS_STATUS, 32'h0);
		chk("status", 32'h9, 32'(rd[4:0]));
		chk("enables", 32'he, 32'({phy, an, wde, xcvr}));
		chk("pads", 32'h3, 32'({dp_oe_n, dm_oe_n}));
		apb(0, OFS_FLAG, 32'h0);
		chk("flag", 32'h7003, 32'(rd[15:0]));
		apb(1, OFS_FLAG, 32'h3);
		apb(0, OFS_FLAG, 32'h0);
		chk("flag_evt", 32'h7, 32'(rd[15:12]));
		apb(0, 12'h0f0, 32'h0);
		chk("slverr", 32'h1, 32'(er));
		apb(1, OFS_IRQ_EN, 32'h1f);
		chk("irq_idle", 32'h0, 32'(irq));
		pls(3'h4);
		chk("evt", 32'h2, 32'({evt, evt_oe_n}));
		chk("exit", 32'h3, 32'({n_conn[1:0], xcvr}));
		chk("pad_core", 32'h2, 32'({dp_out, dp_oe_n}));
		chk("irq_set", 32'h1, 32'(irq));
		apb(1, OFS_IRQ_CLR, 32'h1f);
		apb(0, OFS_IRQ_STAT, 32'h0);
		chk("irq_clr", 32'h0, 32'({rd[4:0], irq}));
		pls(3'h4);
		bad = 0;
		repeat (200) @(posedge pclk) if (evt !== 1'b1) bad = 1;
		chk("static", 32'h0, 32'(bad));
		chk("one_exit", 32'h1, 32'(n_conn));
		chk("host_power", 32'h1, 32'(host_pwr));
		rst(1'b1);
		apb(0, OFS_STATUS, 32'h0);
		chk("reenter", 32'h2, 32'({rd[2:0], evt}));
		ext <= 0;
		repeat (6) @(posedge pclk);
		ext <= 1;
		repeat (6) @(posedge pclk);
		chk("ext_evt", 32'h1, 32'(evt));
		rst(1'b0);
		apb(0, OFS_STATUS, 32'h0);
		chk("normal", 32'h2, 32'(rd[1:0]));
		chk("enum", 32'h1, 32'(n_conn));
		susp <= 1;
		rwuf <= 1;
		apb(1, OFS_WAKE_EN, 32'h1);
		pls(3'h2);
		chk("rwake", 32'h1, 32'(n_rwr));
		pls(3'h1);
		chk("rwake_off", 32'h1, 32'(n_rwr));
		rwuf <= 0;
		pls(3'h2);
		chk("rwake_feat", 32'h1, 32'(n_rwr));
		// Pin deselected: event pin must be released
		apb(1, OFS_FLAG, 32'h3);
		repeat (2) @(posedge pclk);
		chk("pin_off", 32'h3, 32'({evt, evt_oe_n}));
		conclude();
	end
endmodule : dwr_wake_ready_tb_top
